// ===== include/nafs_pkg.sv
// constants and types for the active field sequencer
`default_nettype none
package nafs_pkg;
	localparam logic [3:0] CMD_NONE         = 4'h0;
	localparam logic [3:0] CMD_INIT_FIELD   = 4'h1;
	localparam logic [3:0] CMD_RESP_FIELD   = 4'h2;
	localparam logic [3:0] CMD_TRANSMIT     = 4'h3;
	localparam logic [3:0] CMD_PRESET       = 4'h4;
	localparam logic [3:0] CMD_START_MASK   = 4'h5;
	localparam logic [3:0] CMD_GO_NORMAL    = 4'h6;
	localparam logic [3:0] ADDR_MODE        = 4'h0;
	localparam logic [3:0] ADDR_OPCTL       = 4'h1;
	localparam logic [3:0] ADDR_TIMERS      = 4'h2;
	localparam logic [3:0] ADDR_RATE        = 4'h3;
	localparam logic [3:0] ADDR_STATUS      = 4'h4;
	localparam logic [3:0] ADDR_IRQ         = 4'h5;
	localparam logic [3:0] ADDR_CMD         = 4'h6;
	localparam int MODE_ACTIVE_BIT = 0;
	localparam int MODE_TARGET_BIT = 1;
	localparam int MODE_AUTO_BIT   = 2;
	localparam int MODE_RATEDET_BIT = 3;
	localparam int MODE_N_LO_BIT   = 4;
	localparam int MODE_N_HI_BIT   = 5;
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_COLL  = 1;
	localparam int IRQ_EON   = 2;
	localparam int IRQ_EOF   = 3;
	localparam int IRQ_NRT   = 4;
	localparam int IRQ_W     = 5;
	localparam logic [1:0] RATE_106 = 2'h0;
	localparam logic [1:0] RATE_212 = 2'h1;
	localparam logic [1:0] RATE_424 = 2'h2;
	localparam logic [7:0] DIV_106 = 8'h80;
	localparam logic [7:0] DIV_212 = 8'h40;
	localparam logic [7:0] DIV_424 = 8'h20;
	localparam int CLK_MHZ = 125;
	localparam int AVOID_US = 8;
	localparam int GUARD_INIT_US = 40;
	localparam int GUARD_RESP_US = 10;
	localparam int AVOID_CYC = AVOID_US * CLK_MHZ;
	localparam int GUARD_INIT_CYC = GUARD_INIT_US * CLK_MHZ;
	localparam int GUARD_RESP_CYC = GUARD_RESP_US * CLK_MHZ;
	localparam int TIMER_UNIT_CYC = 16;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_AVOID  = 7'h02,
		ST_GUARD  = 7'h04,
		ST_FIELD  = 7'h08,
		ST_HOLD   = 7'h10,
		ST_LISTEN = 7'h20,
		ST_MASK   = 7'h40
	} nafs_state_t;
endpackage
`default_nettype wire

// ===== logic/nafs_top.sv
// active field sequencer: register port, field-on sequences, timers
`timescale 1ns/1ps
`default_nettype none
module nafs_top #(
	parameter int GUARD_INIT_CYCLES = nafs_pkg::GUARD_INIT_CYC
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic        ext_field_i,
	input  wire logic        rx_start_i,
	input  wire logic        tx_done_i,
	input  wire logic [1:0]  rx_rate_i,
	input  wire logic        rx_rate_valid_i,
	output logic             tx_start_o,
	output logic             transmitter_enable_o,
	output logic             field_detector_enable_o,
	output logic             detector_use_avoid_threshold_o,
	output logic             rx_watch_o,
	output logic             am_channel_enable_o,
	output logic             pm_channel_enable_o,
	output logic             transport_frame_106_enable_o,
	output logic             low_power_o,
	output logic [7:0]       bit_rate_divider_o,
	output logic [nafs_pkg::IRQ_W-1:0] irq_flags_o
);
	localparam int IRQ_BITS = nafs_pkg::IRQ_W;
	localparam int CW = 16;

	typedef struct packed {
		nafs_pkg::nafs_state_t st;
		logic [5:0]  mode;
		logic [7:0]  opctl;
		logic [7:0]  gp_time;
		logic [7:0]  nrt_time;
		logic [7:0]  mask_time;
		logic [1:0]  rate_def;
		logic [1:0]  rate_det;
		logic        initial_cmd;
		logic [CW-1:0] cnt;
		logic [IRQ_BITS-1:0] irq;
		logic        am_en;
		logic        pm_en;
		logic        tf_en;
		logic        tx_start;
		logic        rx_watch;
		logic        rx_started;
		logic [1:0]  ext_sync;
		logic        ext_prev;
		logic [1:0]  rxs_sync;
		logic [31:0] rdata;
	} nafs_regs_t;

	nafs_regs_t r;
	nafs_regs_t next_r;
	logic ext_on;
	logic rx_seen;
	logic [CW-1:0] gp_cyc;
	logic [CW-1:0] nrt_cyc;
	logic [CW-1:0] mask_cyc;
	logic [CW-1:0] guard_cyc;
	logic [3:0] cmd;
	logic peer_rise;
	logic peer_fall;
	logic [IRQ_BITS-1:0] set_irq;

	assign ext_on    = r.ext_sync[1];
	assign rx_seen   = r.rxs_sync[1];
	assign peer_rise = ext_on & ~r.ext_prev;
	assign peer_fall = ~ext_on & r.ext_prev;
	assign gp_cyc    = CW'(r.gp_time) * CW'(nafs_pkg::TIMER_UNIT_CYC);
	assign nrt_cyc   = CW'(r.nrt_time) * CW'(nafs_pkg::TIMER_UNIT_CYC);
	assign mask_cyc  = CW'(r.mask_time) * CW'(nafs_pkg::TIMER_UNIT_CYC);
	assign guard_cyc = r.initial_cmd ? CW'(GUARD_INIT_CYCLES) : CW'(nafs_pkg::GUARD_RESP_CYC);
	assign cmd       = (wr_i && addr_i == nafs_pkg::ADDR_CMD) ? wdata_i[3:0] : nafs_pkg::CMD_NONE;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		set_irq = '0;
		next_r.tx_start = 1'b0;
		next_r.ext_sync = {r.ext_sync[0], ext_field_i};
		next_r.rxs_sync = {r.rxs_sync[0], rx_start_i};
		next_r.ext_prev = ext_on;
		next_r.rdata = 32'h0000_0000;
		if (r.cnt != '0) begin
			next_r.cnt = r.cnt - CW'(1);
		end
		if (wr_i) begin
			case (addr_i)
				nafs_pkg::ADDR_MODE:   next_r.mode = wdata_i[5:0];
				nafs_pkg::ADDR_OPCTL:  next_r.opctl = wdata_i[7:0];
				nafs_pkg::ADDR_TIMERS: begin
					next_r.gp_time   = wdata_i[7:0];
					next_r.nrt_time  = wdata_i[15:8];
					next_r.mask_time = wdata_i[23:16];
				end
				nafs_pkg::ADDR_RATE:   next_r.rate_def = wdata_i[1:0];
				default: ;
			endcase
		end
		// set wins over software clear
		if (wr_i && addr_i == nafs_pkg::ADDR_IRQ) begin
			next_r.irq = r.irq & ~wdata_i[IRQ_BITS-1:0];
		end
		if (cmd == nafs_pkg::CMD_PRESET) begin
			next_r.am_en = 1'b1;
			next_r.pm_en = 1'b0;
			next_r.tf_en = 1'b1;
		end
		if (cmd == nafs_pkg::CMD_GO_NORMAL) begin
			next_r.rate_def = r.rate_det;
			next_r.mode[nafs_pkg::MODE_RATEDET_BIT] = 1'b0;
		end
		if (rx_rate_valid_i && r.mode[nafs_pkg::MODE_TARGET_BIT]
			&& r.mode[nafs_pkg::MODE_RATEDET_BIT]) begin
			next_r.rate_det = rx_rate_i;
		end
		if (peer_rise && r.st != nafs_pkg::ST_AVOID) begin
			set_irq[nafs_pkg::IRQ_EON] = 1'b1;
		end
		case (r.st)
			nafs_pkg::ST_IDLE: begin
				if (cmd == nafs_pkg::CMD_INIT_FIELD || cmd == nafs_pkg::CMD_RESP_FIELD) begin
					next_r.initial_cmd = (cmd == nafs_pkg::CMD_INIT_FIELD);
					next_r.cnt = CW'(nafs_pkg::AVOID_CYC);
					next_r.st = nafs_pkg::ST_AVOID;
				end else if (cmd == nafs_pkg::CMD_START_MASK) begin
					next_r.cnt = mask_cyc;
					next_r.rx_started = 1'b0;
					next_r.st = nafs_pkg::ST_MASK;
				end else if (r.mode[nafs_pkg::MODE_TARGET_BIT] && r.opctl == 8'h00 && peer_rise) begin
					next_r.st = nafs_pkg::ST_IDLE;
				end
			end
			nafs_pkg::ST_AVOID: begin
				if (ext_on) begin
					set_irq[nafs_pkg::IRQ_COLL] = 1'b1;
					next_r.st = nafs_pkg::ST_IDLE;
				end else if (r.cnt == '0) begin
					next_r.cnt = guard_cyc;
					next_r.st = nafs_pkg::ST_GUARD;
				end
			end
			nafs_pkg::ST_GUARD: begin
				if (r.cnt == '0) begin
					set_irq[nafs_pkg::IRQ_DONE] = 1'b1;
					next_r.st = nafs_pkg::ST_FIELD;
				end
			end
			nafs_pkg::ST_FIELD: begin
				if (cmd == nafs_pkg::CMD_TRANSMIT) begin
					next_r.tx_start = 1'b1;
				end
				if (tx_done_i) begin
					next_r.cnt = gp_cyc;
					next_r.st = nafs_pkg::ST_HOLD;
				end
			end
			nafs_pkg::ST_HOLD: begin
				if (r.cnt == '0) begin
					next_r.cnt = nrt_cyc;
					next_r.st = nafs_pkg::ST_LISTEN;
				end
			end
			nafs_pkg::ST_LISTEN: begin
				if (peer_rise) begin
					next_r.cnt = mask_cyc;
					next_r.rx_started = 1'b0;
					next_r.st = nafs_pkg::ST_MASK;
				end else if (r.cnt == '0) begin
					set_irq[nafs_pkg::IRQ_NRT] = 1'b1;
					next_r.st = nafs_pkg::ST_IDLE;
				end
			end
			nafs_pkg::ST_MASK: begin
				if (peer_fall) begin
					set_irq[nafs_pkg::IRQ_EOF] = 1'b1;
					next_r.rx_watch = 1'b0;
					if (r.mode[nafs_pkg::MODE_AUTO_BIT]) begin
						next_r.initial_cmd = 1'b0;
						next_r.cnt = CW'(nafs_pkg::AVOID_CYC);
						next_r.st = nafs_pkg::ST_AVOID;
					end else begin
						next_r.st = nafs_pkg::ST_IDLE;
					end
				end else if (r.cnt == '0 && !r.rx_started) begin
					next_r.rx_watch = 1'b1;
				end
			end
			default: next_r.st = nafs_pkg::ST_IDLE;
		endcase
		if (r.st != nafs_pkg::ST_MASK) begin
			next_r.rx_watch = 1'b0;
		end
		// an expired mask timer must not re-arm the watch once the reply has begun
		if (rx_seen && r.rx_watch) begin
			next_r.rx_watch = 1'b0;
			next_r.rx_started = 1'b1;
		end
		next_r.irq = next_r.irq | set_irq;
		if (rd_i) begin
			case (addr_i)
				nafs_pkg::ADDR_MODE:   next_r.rdata = {26'h0, r.mode};
				nafs_pkg::ADDR_OPCTL:  next_r.rdata = {24'h0, r.opctl};
				nafs_pkg::ADDR_TIMERS: next_r.rdata = {8'h0, r.mask_time, r.nrt_time, r.gp_time};
				nafs_pkg::ADDR_RATE:   next_r.rdata = {26'h0, r.rate_det, 2'h0, r.rate_def};
				nafs_pkg::ADDR_STATUS: next_r.rdata = {25'h0, r.st};
				nafs_pkg::ADDR_IRQ:    next_r.rdata = {27'h0, r.irq};
				default:               next_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.st <= nafs_pkg::ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic active_mode;
	logic [1:0] eff_rate;
	assign active_mode = r.mode[nafs_pkg::MODE_ACTIVE_BIT] | r.mode[nafs_pkg::MODE_TARGET_BIT];
	assign eff_rate = r.rate_def;

	always_comb begin
		case (eff_rate)
			nafs_pkg::RATE_212: bit_rate_divider_o = nafs_pkg::DIV_212;
			nafs_pkg::RATE_424: bit_rate_divider_o = nafs_pkg::DIV_424;
			default:            bit_rate_divider_o = nafs_pkg::DIV_106;
		endcase
	end

	// transmitter follows the sequencer only; opctl cannot turn it on
	assign transmitter_enable_o = (r.st == nafs_pkg::ST_GUARD) || (r.st == nafs_pkg::ST_FIELD)
		|| (r.st == nafs_pkg::ST_HOLD);
	assign field_detector_enable_o = active_mode;
	assign detector_use_avoid_threshold_o = (r.st == nafs_pkg::ST_AVOID);
	assign low_power_o = r.mode[nafs_pkg::MODE_TARGET_BIT] && r.opctl == 8'h00;
	assign rdata_o = r.rdata;
	assign tx_start_o = r.tx_start;
	assign rx_watch_o = r.rx_watch;
	assign am_channel_enable_o = r.am_en;
	assign pm_channel_enable_o = r.pm_en;
	assign transport_frame_106_enable_o = r.tf_en;
	assign irq_flags_o = r.irq;

	////////////////////////////////////////////////////////////////////////////
	sequence s_collide;
		r.st == nafs_pkg::ST_AVOID && ext_on;
	endsequence
	a_collision_irq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_collide |=> r.irq[nafs_pkg::IRQ_COLL] && r.st == nafs_pkg::ST_IDLE)
		else $error("collision not flagged");
	a_done_irq_field: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(r.irq[nafs_pkg::IRQ_DONE]) |-> r.st == nafs_pkg::ST_FIELD)
		else $error("done irq without field on");
	a_tx_enable_seq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(transmitter_enable_o) |-> $past(r.st) == nafs_pkg::ST_AVOID && !$past(ext_on))
		else $error("transmitter enabled outside sequence");
	a_avoid_thresh: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		detector_use_avoid_threshold_o |-> transmitter_enable_o == 1'b0)
		else $error("threshold wrong");
	a_field_off_after: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		r.st == nafs_pkg::ST_FIELD && tx_done_i |=> r.st == nafs_pkg::ST_HOLD && r.cnt == gp_cyc)
		else $error("field hold not started");
	a_nrt_timeout: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		r.st == nafs_pkg::ST_LISTEN && r.cnt == '0 && !peer_rise |=> r.irq[nafs_pkg::IRQ_NRT])
		else $error("no-response irq missing");
	a_eon_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		r.st == nafs_pkg::ST_LISTEN && peer_rise |=> r.irq[nafs_pkg::IRQ_EON]
		&& r.st == nafs_pkg::ST_MASK && !r.rx_watch)
		else $error("field-on handling wrong");
	a_auto_resp: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		r.st == nafs_pkg::ST_MASK && peer_fall && r.mode[nafs_pkg::MODE_AUTO_BIT]
		|=> r.st == nafs_pkg::ST_AVOID && r.irq[nafs_pkg::IRQ_EOF])
		else $error("auto response not started");
	a_preset_chan: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd == nafs_pkg::CMD_PRESET |=> am_channel_enable_o && !pm_channel_enable_o
		&& transport_frame_106_enable_o)
		else $error("preset wrong");
	a_go_normal: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd == nafs_pkg::CMD_GO_NORMAL |=> r.rate_def == $past(r.rate_det)
		&& !r.mode[nafs_pkg::MODE_RATEDET_BIT])
		else $error("go normal failed");
	a_tx_start_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		tx_start_o |-> $past(r.st) == nafs_pkg::ST_FIELD)
		else $error("transmit started outside field state");
	a_rate_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		rx_rate_valid_i && r.mode[nafs_pkg::MODE_TARGET_BIT] && r.mode[nafs_pkg::MODE_RATEDET_BIT]
		|=> r.rate_det == $past(rx_rate_i))
		else $error("detected rate not stored");
	a_start_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		r.st == nafs_pkg::ST_IDLE && cmd == nafs_pkg::CMD_START_MASK
		|=> r.st == nafs_pkg::ST_MASK && !r.rx_watch)
		else $error("mask timer not started");
	a_watch_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		r.rx_watch && rx_seen |=> !r.rx_watch)
		else $error("receiver watch not ended");
	a_target_eon: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		r.st == nafs_pkg::ST_IDLE && peer_rise |=> r.irq[nafs_pkg::IRQ_EON])
		else $error("idle field-on irq missing");
endmodule
`default_nettype wire

// ===== tb/nafs_peer.sv
// peer rf device model: answers the device field with a field of its own
`timescale 1ns/1ps
`default_nettype none
module nafs_peer (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       dev_field_i,
	input  wire logic       respond_i,
	input  wire logic       force_i,
	input  wire logic [7:0] delay_i,
	output logic            field_o,
	output logic            rx_start_o
);
	logic        last_field;
	logic        busy;
	logic [15:0] cnt;
	logic [15:0] dly;
	assign dly = {8'h00, delay_i};
	// the delay is not latched; the bench sets it once, to a value from 16 to 47, before the answers it checks
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_field <= 1'b0;
			busy <= 1'b0;
			cnt <= 16'h0000;
		end else begin
			last_field <= dev_field_i;
			if (last_field && !dev_field_i && respond_i) begin
				busy <= 1'b1;
				cnt <= 16'h0000;
			end else if (busy) begin
				cnt <= cnt + 16'h0001;
				if (cnt == dly + 16'h00C8) begin
					busy <= 1'b0;
				end
			end
		end
	end
	assign field_o = force_i | (busy && cnt >= dly);
	assign rx_start_o = busy && (cnt == dly + 16'h0040);
endmodule
`default_nettype wire

// ===== tb/nfc_active_field_sequencer_bench.sv
// self-checking bench for the active field sequencer
`timescale 1ns/1ps
`default_nettype none
module nfc_active_field_sequencer_bench;
	localparam int GI = 20;
	localparam int GP = 2;
	localparam int NR = 4;
	localparam int MK = 1;
	localparam int RSP = nafs_pkg::AVOID_CYC + nafs_pkg::GUARD_RESP_CYC;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, v, rnd = 32'h0001144D;
	logic wr_s = 1'b0, rd_s = 1'b0, tx_done = 1'b0, rate_vld = 1'b0;
	logic [1:0] rate = 2'h0, r;
	logic ext, rxs, tx_st, te, fde, thr, rxw, am, pm, tf, lp, respond = 1'b0, frc = 1'b0;
	logic [7:0] div, dly = 8'h10;
	logic [nafs_pkg::IRQ_W-1:0] irq;
	logic [6:0] obs;
	int err_total = 0, num_checks = 0, tx_cnt = 0, te_cnt = 0;
	logic te_q = 1'b0;
	assign obs = {rxw, te, irq};
	always #4 clk = ~clk;
	nafs_top #(.GUARD_INIT_CYCLES(GI)) dut_u (.ref_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .ext_field_i(ext),
		.rx_start_i(rxs), .tx_done_i(tx_done), .rx_rate_i(rate), .rx_rate_valid_i(rate_vld),
		.tx_start_o(tx_st), .transmitter_enable_o(te), .field_detector_enable_o(fde),
		.detector_use_avoid_threshold_o(thr), .rx_watch_o(rxw), .am_channel_enable_o(am),
		.pm_channel_enable_o(pm), .transport_frame_106_enable_o(tf), .low_power_o(lp),
		.bit_rate_divider_o(div), .irq_flags_o(irq));
	nafs_peer peer_u (.clk_i(clk), .rst_n_i(rst_n), .dev_field_i(te), .respond_i(respond),
		.force_i(frc), .delay_i(dly), .field_o(ext), .rx_start_o(rxs));
	always @(posedge clk) begin
		if (tx_st === 1'b1) tx_cnt++;
		if (te === 1'b1 && te_q !== 1'b1) te_cnt++;
		te_q <= te;
	end
	function automatic logic [7:0] div_of(input logic [1:0] x);
		case (x)
			nafs_pkg::RATE_212: return nafs_pkg::DIV_212;
			nafs_pkg::RATE_424: return nafs_pkg::DIV_424;
			default: return nafs_pkg::DIV_106;
		endcase
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask
	// waits for one observed bit under a bound and checks the elapsed cycles
	task automatic wt(input string nm, input int i, input logic b, input int lo, input int hi);
		int n;
		n = 0;
		while (obs[i] !== b && n <= hi) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(nm, 32'h1, {31'h0, n >= lo && n <= hi});
	endtask
	task automatic fon;
		wr(nafs_pkg::ADDR_CMD, {28'h0, nafs_pkg::CMD_INIT_FIELD});
		repeat (100) @(posedge clk);
		#1;
		chk("avoid threshold", 32'h1, {31'h0, thr});
		wt("initial guard", nafs_pkg::IRQ_DONE, 1'b1, 900 + GI - 10, 900 + GI + 10);
		chk("tx enable", 32'h1, {31'h0, te});
		chk("peer threshold", 32'h0, {31'h0, thr});
	endtask
	task automatic xmit;
		int c;
		c = tx_cnt;
		wr(nafs_pkg::ADDR_CMD, {28'h0, nafs_pkg::CMD_TRANSMIT});
		repeat (4) @(posedge clk);
		tx_done <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		chk("tx start", c + 1, tx_cnt);
		wt("field off", 5, 1'b0, GP * 16 - 3, GP * 16 + 6);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#(8 * 40000);
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("reset divider", 32'h80, {24'h0, div});
		rd(nafs_pkg::ADDR_STATUS, v);
		chk("state", {25'h0, nafs_pkg::ST_IDLE}, v);
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			r = (k < 3) ? k[1:0] : 2'(rnd % 3);
			wr(nafs_pkg::ADDR_RATE, {30'h0, r});
			@(posedge clk);
			#1;
			chk("divider", {24'h0, div_of(r)}, {24'h0, div});
		end
		wr(nafs_pkg::ADDR_MODE, 32'h00000005);
		wr(nafs_pkg::ADDR_CMD, {28'h0, nafs_pkg::CMD_PRESET});
		wr(nafs_pkg::ADDR_TIMERS, {8'h00, 8'(MK), 8'(NR), 8'(GP)});
		#1;
		chk("detector", 32'h1, {31'h0, fde});
		chk("am pm frame", 32'h5, {29'h0, am, pm, tf});
		wr(nafs_pkg::ADDR_CMD, {28'h0, nafs_pkg::CMD_TRANSMIT});
		repeat (3) @(posedge clk);
		chk("idle transmit", 0, tx_cnt);
		wr(nafs_pkg::ADDR_CMD, {28'h0, nafs_pkg::CMD_INIT_FIELD});
		repeat (100) @(posedge clk);
		frc <= 1'b1;
		wt("collision", nafs_pkg::IRQ_COLL, 1'b1, 0, 950);
		frc <= 1'b0;
		rd(nafs_pkg::ADDR_STATUS, v);
		chk("state", {25'h0, nafs_pkg::ST_IDLE}, v);
		chk("no field", 0, te_cnt);
		repeat (5) @(posedge clk);
		wr(nafs_pkg::ADDR_IRQ, 32'h1F);
		fon();
		wr(nafs_pkg::ADDR_IRQ, 32'h1F);
		rnd = lfsr(rnd);
		dly <= 8'(rnd % 32 + 16);
		respond <= 1'b1;
		xmit();
		wt("peer on", nafs_pkg::IRQ_EON, 1'b1, 0, 120);
		wt("mask", 6, 1'b1, MK * 16 - 2, MK * 16 + 6);
		wt("rx start", 6, 1'b0, 40, 55);
		repeat (4) @(posedge clk);
		#1;
		chk("watch stays off", 32'h0, {31'h0, rxw});
		wt("peer off", nafs_pkg::IRQ_EOF, 1'b1, 100, 220);
		wt("response guard", nafs_pkg::IRQ_DONE, 1'b1, RSP - 10, RSP + 10);
		wr(nafs_pkg::ADDR_IRQ, 32'h1F);
		wr(nafs_pkg::ADDR_MODE, 32'h00000001);
		v = te_cnt;
		xmit();
		wt("peer off", nafs_pkg::IRQ_EOF, 1'b1, 0, 400);
		repeat (2600) @(posedge clk);
		chk("no reactivation", v, te_cnt);
		chk("no done", 32'h0, {31'h0, irq[nafs_pkg::IRQ_DONE]});
		wr(nafs_pkg::ADDR_IRQ, 32'h1F);
		respond <= 1'b0;
		fon();
		xmit();
		wt("no response", nafs_pkg::IRQ_NRT, 1'b1, NR * 16 - 3, NR * 16 + 6);
		wr(nafs_pkg::ADDR_IRQ, 32'h1F);
		wr(nafs_pkg::ADDR_MODE, 32'h0000000E);
		wr(nafs_pkg::ADDR_OPCTL, 32'h0);
		#1;
		chk("target detector", 32'h1, {31'h0, fde});
		chk("low power", 32'h1, {31'h0, lp});
		frc <= 1'b1;
		wt("target peer on", nafs_pkg::IRQ_EON, 1'b1, 0, 10);
		rnd = lfsr(rnd);
		wr(nafs_pkg::ADDR_OPCTL, {24'h0, rnd[7:0] | 8'h01});
		#1;
		chk("awake", 32'h0, {31'h0, lp});
		wr(nafs_pkg::ADDR_CMD, {28'h0, nafs_pkg::CMD_START_MASK});
		wt("start mask", 6, 1'b1, MK * 16 - 2, MK * 16 + 6);
		r = 2'(rnd[15:8] % 3);
		wr(nafs_pkg::ADDR_RATE, {30'h0, 2'((r + 2'h1) % 3)});
		@(posedge clk);
		rate <= r;
		rate_vld <= 1'b1;
		@(posedge clk);
		rate_vld <= 1'b0;
		rd(nafs_pkg::ADDR_RATE, v);
		chk("detected", {30'h0, r}, {30'h0, v[5:4]});
		wr(nafs_pkg::ADDR_CMD, {28'h0, nafs_pkg::CMD_GO_NORMAL});
		rd(nafs_pkg::ADDR_RATE, v);
		chk("normal rate", {30'h0, r}, {30'h0, v[1:0]});
		chk("normal divider", {24'h0, div_of(r)}, {24'h0, div});
		frc <= 1'b0;
		report_and_stop();
	end
endmodule
`default_nettype wire
